// File: hw/exc_ctrl_pkg.sv
// Shared constants and types of the exception and interrupt priority controller.
package exc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Masking modes and entry sequence states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_GLOBAL   = 2'h0,
    MODE_USER     = 2'h1,
    MODE_LEVEL    = 2'h2,
    MODE_COMBINED = 2'h3
  } mask_mode_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PUSH_PC,
    ST_PUSH_FLAGS,
    ST_MASK_UPDATE,
    ST_FETCH
  } entry_state_type;

  // ----------------------------------------------------------------
  // Pin sense codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_FALL      = 2'h1;
  localparam logic [1:0] SENSE_RISE      = 2'h2;
  localparam logic [1:0] SENSE_BOTH      = 2'h3;

  // ----------------------------------------------------------------
  // Vector numbers
  // ----------------------------------------------------------------
  localparam int         VEC_W         = 8;
  localparam logic [7:0] VEC_NMI       = 8'h07;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h08;
  localparam logic [7:0] VEC_SRC_BASE  = 8'h0C;

  // ----------------------------------------------------------------
  // Priority levels and reset values
  // ----------------------------------------------------------------
  localparam int         LEVEL_W      = 3;
  localparam logic [2:0] LEVEL_TOP    = 3'h7;
  localparam logic [2:0] LEVEL_RESET  = 3'h7;
  localparam logic       GMASK_RESET  = 1'b1;
  localparam logic       UMASK_RESET  = 1'b0;

  // ----------------------------------------------------------------
  // Response time budget
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_PS      = 40000;
  localparam int         MAX_LATENCY_PS     = 1500000;
  localparam int         MAX_LATENCY_CYCLES = MAX_LATENCY_PS / CLK_PERIOD_PS;
  localparam int         LAT_W              = 8;

endpackage

// File: hw/pin_request_detect.sv
// Request detector for one external request pin with level or edge sensing.
`timescale 1ns/100ps
module pin_request_detect
  import exc_ctrl_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       pin_i,
  input  wire logic [1:0] sense_i,
  input  wire logic       clear_i,
  output logic            request_o
);

  typedef struct packed {
    logic prev;
    logic pending;
  } detect_state_type;

  detect_state_type state_q;
  detect_state_type state_d;
  logic             edge_seen;

  // ----------------------------------------------------------------
  // Edge detection and pending flag
  // ----------------------------------------------------------------

  // An edge sets the pending flag; a new edge wins over a clear in the same cycle.
  always_comb begin
    state_d      = state_q;
    state_d.prev = pin_i;
    unique case (sense_i)
      SENSE_FALL: edge_seen = state_q.prev & ~pin_i;
      SENSE_RISE: edge_seen = ~state_q.prev & pin_i;
      SENSE_BOTH: edge_seen = state_q.prev ^ pin_i;
      SENSE_LOW_LEVEL: edge_seen = 1'b0;
    endcase
    if (clear_i) begin
      state_d.pending = 1'b0;
    end
    if (edge_seen) begin
      state_d.pending = 1'b1; // R20
    end
    if (sense_i == SENSE_LOW_LEVEL) begin
      state_d.pending = 1'b0;
    end
  end

  // Level sense follows the live pin; edge sense reports the pending flag.
  assign request_o = (sense_i == SENSE_LOW_LEVEL) ? ~pin_i : state_q.pending; // R20

  // Registers the detector state.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= '{prev: 1'b1, pending: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// File: hw/exception_interrupt_priority_ctrl.sv
// Exception and interrupt priority controller driving the CPU exception entry sequence.
//
// Operation
// [R01] Simultaneous requests are accepted one by one, highest priority first.
// [R02] Software traps are always accepted in program execution state, ignoring masks.
// [R03] Entry pushes program counter and flags, updates masks, then fetches vector.
// [R04] Every source has its own distinct vector number.
// [R05] Non-maskable input selects rising or falling edge and ignores mask bits.
// [R06] Older core: each pin senses low level or falling edge only.
// [R07] Newer core: each pin senses low level, rising, falling or both edges.
// [R08] The trap operand selects one of four trap vectors.
// [R09] Compatible mode: global mask set blocks all maskable, clear allows all.
// [R10] Compatible mode: accepting an interrupt sets the global mask bit.
// [R11] Advanced mode: user mask lets raised-priority sources preempt low handlers.
// [R12] Per-source programmable priorities steer arbitration and masking.
// [R13] Modes 0 to 3 exist; mode 0 uses the global mask bit only.
// [R14] Mode 1 uses global mask and user mask bits together.
// [R15] Mode 2 uses eight levels: 3-bit mask level and source priorities.
// [R16] Mode 3 combines user masking with level masking for nine levels.
// [R17] Request to service routine start stays within the response time budget.
// [R18] An accepted request during sleep restarts the CPU immediately.
// [R19] Level modes accept priority above mask level and store accepted level.
// [R20] Edge requests latch pending until accepted; level requests follow the pin.
`timescale 1ns/100ps
module exception_interrupt_priority_ctrl
  import exc_ctrl_pkg::*;
#(
  parameter int NUM_PINS   = 8,
  parameter int NUM_PERIPH = 8
) (
  input  wire logic                                    clock_i,
  input  wire logic                                    reset_n_i,
  input  wire logic                                    nmi_pin_i,
  input  wire logic                                    nmi_rising_i,
  input  wire logic [NUM_PINS-1:0]                     irq_pin_i,
  input  wire logic [2*NUM_PINS-1:0]                   irq_sense_i,
  input  wire logic                                    older_core_i,
  input  wire logic [NUM_PERIPH-1:0]                   periph_req_i,
  input  wire logic [LEVEL_W*(NUM_PINS+NUM_PERIPH)-1:0] source_priority_register_i,
  input  wire logic [1:0]                              mode_i,
  input  wire logic                                    global_mask_i,
  input  wire logic                                    user_mask_bit_i,
  input  wire logic [LEVEL_W-1:0]                      mask_level_field_i,
  input  wire logic                                    trap_req_i,
  input  wire logic [1:0]                              trap_operand_i,
  input  wire logic                                    cpu_executing_i,
  input  wire logic                                    cpu_sleeping_i,
  input  wire logic                                    stack_ack_i,
  input  wire logic                                    fetch_ack_i,
  output logic                                         push_pc_o,
  output logic                                         push_flags_o,
  output logic                                         mask_write_o,
  output logic                                         global_mask_o,
  output logic                                         user_mask_bit_o,
  output logic [LEVEL_W-1:0]                           mask_level_field_o,
  output logic                                         fetch_vector_o,
  output logic [VEC_W-1:0]                             vector_o,
  output logic                                         service_start_o,
  output logic                                         wake_o,
  output logic                                         latency_error_o
);

  localparam int NUM_SRC = NUM_PINS + NUM_PERIPH;
  localparam int SRC_W   = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

  typedef struct packed {
    entry_state_type      state;
    logic [VEC_W-1:0]     vector;
    logic                 trap_pending;
    logic [1:0]           trap_num;
    logic [NUM_PINS:0]    clear;
    logic                 new_gmask;
    logic                 new_umask;
    logic [LEVEL_W-1:0]   new_level;
    logic                 push_pc;
    logic                 push_flags;
    logic                 mask_write;
    logic                 fetch;
    logic                 service_start;
    logic                 wake;
    logic [LAT_W-1:0]     lat_count;
    logic                 lat_error;
  } ctrl_state_type;

  ctrl_state_type           state_q;
  ctrl_state_type           state_d;
  logic [NUM_PINS-1:0]      pin_req;
  logic                     nmi_req;
  logic [NUM_SRC-1:0]       src_req;
  logic [NUM_SRC-1:0]       src_ok;
  logic [LEVEL_W-1:0]       src_prio [NUM_SRC];
  logic                     best_valid;
  logic [SRC_W-1:0]         best_idx;
  logic [LEVEL_W-1:0]       best_prio;
  logic                     trap_ok;
  logic                     any_accept;
  mask_mode_type            mode;

  assign mode = mask_mode_type'(mode_i);

  // ----------------------------------------------------------------
  // Request detection
  // ----------------------------------------------------------------

  // The non-maskable input is an edge source whose direction is selectable.
  pin_request_detect u_nmi_detect (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .pin_i     (nmi_pin_i),
    .sense_i   (nmi_rising_i ? SENSE_RISE : SENSE_FALL), // R05
    .clear_i   (state_q.clear[NUM_PINS]),
    .request_o (nmi_req)
  );

  // One detector per external pin; the older core folds any edge mode into falling edge.
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic [1:0] sense;
    assign sense = (older_core_i && irq_sense_i[2*p +: 2] != SENSE_LOW_LEVEL) ?
                   SENSE_FALL : irq_sense_i[2*p +: 2]; // R06 R07
    pin_request_detect u_detect (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .pin_i     (irq_pin_i[p]),
      .sense_i   (sense),
      .clear_i   (state_q.clear[p]),
      .request_o (pin_req[p])
    );
  end

  assign src_req = {periph_req_i, pin_req};

  // ----------------------------------------------------------------
  // Per-source masking
  // ----------------------------------------------------------------

  // Each source is checked against the mask scheme of the current mode.
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_mask
    logic raised;
    logic above;
    assign src_prio[s] = source_priority_register_i[LEVEL_W*s +: LEVEL_W]; // R12
    // Raised priority means any nonzero programmed priority.
    assign raised      = (src_prio[s] != '0);
    assign above       = (src_prio[s] > mask_level_field_i); // R19
    always_comb begin
      unique case (mode)
        MODE_GLOBAL:   src_ok[s] = !global_mask_i; // R09 R13
        MODE_USER:     src_ok[s] = !global_mask_i || (!user_mask_bit_i && raised); // R11 R14
        MODE_LEVEL:    src_ok[s] = above; // R15
        MODE_COMBINED: src_ok[s] = above && (!global_mask_i || (!user_mask_bit_i && raised)); // R16
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------

  // Picks the highest priority eligible source; the lowest index wins a tie.
  always_comb begin
    best_valid = 1'b0;
    best_idx   = '0;
    best_prio  = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (src_req[s] && src_ok[s] && (!best_valid || src_prio[s] > best_prio)) begin // R01 R12
        best_valid = 1'b1;
        best_idx   = SRC_W'(s);
        best_prio  = src_prio[s];
      end
    end
  end

  // A trap waits while the CPU is not executing program code.
  assign trap_ok    = state_q.trap_pending && cpu_executing_i; // R02
  assign any_accept = nmi_req || trap_ok || best_valid;

  // ----------------------------------------------------------------
  // Entry sequence
  // ----------------------------------------------------------------

  // Accepts one request at a time and walks the CPU through the entry steps.
  always_comb begin
    state_d               = state_q;
    state_d.clear         = '0;
    state_d.service_start = 1'b0;
    // A trap pulse is latched with its operand until it is taken.
    if (trap_req_i) begin
      state_d.trap_pending = 1'b1;
      state_d.trap_num     = trap_operand_i;
    end
    // Only the idle state takes a request; the push and fetch states wait for the CPU.
    unique case (state_q.state)
      ST_IDLE: begin
        if (nmi_req) begin
          state_d.state                = ST_PUSH_PC; // R01
          state_d.vector               = VEC_NMI; // R04
          state_d.clear[NUM_PINS]      = 1'b1;
          state_d.new_gmask            = 1'b1;
          state_d.new_umask            = mode[0] ? 1'b1 : user_mask_bit_i;
          state_d.new_level            = mode[1] ? LEVEL_TOP : mask_level_field_i;
        end else if (trap_ok) begin
          state_d.state                = ST_PUSH_PC;
          state_d.vector               = VEC_TRAP_BASE + {6'h00, state_q.trap_num}; // R08
          state_d.trap_pending         = trap_req_i;
          state_d.new_gmask            = 1'b1;
          state_d.new_umask            = mode[0] ? 1'b1 : user_mask_bit_i;
          state_d.new_level            = mask_level_field_i;
        end else if (best_valid) begin
          state_d.state                = ST_PUSH_PC;
          state_d.vector               = VEC_SRC_BASE + VEC_W'(best_idx); // R04
          if (32'(best_idx) < NUM_PINS) begin
            state_d.clear[best_idx]    = 1'b1; // R20
          end
          state_d.new_gmask            = (mode == MODE_LEVEL) ? global_mask_i : 1'b1; // R10
          state_d.new_umask            = (mode[0] && best_prio != '0) ? 1'b1 : user_mask_bit_i; // R11
          state_d.new_level            = mode[1] ? best_prio : mask_level_field_i; // R19
        end
      end
      ST_PUSH_PC: begin
        if (stack_ack_i) begin
          state_d.state = ST_PUSH_FLAGS; // R03
        end
      end
      ST_PUSH_FLAGS: begin
        if (stack_ack_i) begin
          state_d.state = ST_MASK_UPDATE; // R03
        end
      end
      ST_MASK_UPDATE: begin
        state_d.state = ST_FETCH; // R03
      end
      ST_FETCH: begin
        if (fetch_ack_i) begin
          state_d.state         = ST_IDLE;
          state_d.service_start = 1'b1;
        end
      end
    endcase

    // Step strobes are registered copies of the next state.
    state_d.push_pc    = (state_d.state == ST_PUSH_PC);
    state_d.push_flags = (state_d.state == ST_PUSH_FLAGS);
    state_d.mask_write = (state_d.state == ST_MASK_UPDATE);
    state_d.fetch      = (state_d.state == ST_FETCH);

    // A sleeping CPU is woken while an acceptable request waits.
    state_d.wake = cpu_sleeping_i && (nmi_req || best_valid); // R18

    // Counts cycles from a waiting request to the start of its service routine.
    if (state_d.service_start || (state_q.state == ST_IDLE && !any_accept)) begin
      state_d.lat_count = '0;
    end else if (state_q.lat_count != '1) begin
      state_d.lat_count = state_q.lat_count + LAT_W'(1);
    end
    // The overrun flag stays set until reset.
    if (state_q.lat_count >= LAT_W'(MAX_LATENCY_CYCLES)) begin
      state_d.lat_error = 1'b1; // R17
    end
  end

  // Registers the whole controller state.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= '{state: ST_IDLE, new_gmask: GMASK_RESET, new_umask: UMASK_RESET,
                   new_level: LEVEL_RESET, default: '0};
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Every output is taken straight from a state flip-flop.
  assign push_pc_o          = state_q.push_pc;
  assign push_flags_o       = state_q.push_flags;
  assign mask_write_o       = state_q.mask_write;
  assign global_mask_o      = state_q.new_gmask;
  assign user_mask_bit_o    = state_q.new_umask;
  assign mask_level_field_o = state_q.new_level;
  assign fetch_vector_o     = state_q.fetch;
  assign vector_o           = state_q.vector;
  assign service_start_o    = state_q.service_start;
  assign wake_o             = state_q.wake;
  assign latency_error_o    = state_q.lat_error;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  // Entry steps follow in their fixed order.
  step_order_a: assert property (push_pc_o && stack_ack_i |=> push_flags_o) // R03
    else $error("Flags push did not follow program counter push.");
  mask_before_fetch_a: assert property (mask_write_o |=> fetch_vector_o && !mask_write_o) // R03
    else $error("Vector fetch did not follow mask update.");

  // Arbitration order and vector numbers.
  nmi_first_a: assert property (state_q.state == ST_IDLE && nmi_req |=> vector_o == VEC_NMI) // R01 R05
    else $error("Non-maskable request lost arbitration.");
  trap_vector_a: assert property (state_q.state == ST_IDLE && !nmi_req && trap_ok
                                  |=> vector_o == VEC_TRAP_BASE + {6'h00, $past(state_q.trap_num)}) // R02 R08
    else $error("Trap vector wrong or trap refused.");

  // Mode masks block or pass maskable requests.
  global_block_a: assert property (state_q.state == ST_IDLE && mode == MODE_GLOBAL && global_mask_i
                                   && !nmi_req && !trap_ok |=> push_pc_o == 1'b0) // R09 R13
    else $error("Maskable request accepted with global mask set.");
  compat_sets_mask_a: assert property (mask_write_o && mode == MODE_GLOBAL |-> global_mask_o) // R10
    else $error("Global mask not set on acceptance.");
  level_store_a: assert property (state_q.state == ST_IDLE && mode == MODE_LEVEL && !nmi_req && !trap_ok
                                  && best_valid |=> ##2 mask_level_field_o > $past(mask_level_field_i, 3)) // R15 R19
    else $error("Accepted level not above previous mask level.");
  level_gate_a: assert property ((mode == MODE_LEVEL || (mode == MODE_COMBINED && !global_mask_i)) // R16 R19
                                 && !src_ok[0] |-> src_prio[0] <= mask_level_field_i)
    else $error("Level masking blocked a higher priority source.");

  // Sleep exit and response time.
  wake_sleep_a: assert property ($rose(push_pc_o) && $past(cpu_sleeping_i) && !$past(trap_ok) // R18
                                 |-> wake_o)
    else $error("Sleeping CPU not woken by accepted request.");
  latency_flag_a: assert property (state_q.lat_count > LAT_W'(MAX_LATENCY_CYCLES) |-> latency_error_o) // R17
    else $error("Response time overrun not flagged.");

  // An accepted edge request is forgotten unless a new edge came.
  edge_clear_a: assert property (state_q.clear[0] && irq_sense_i[1:0] != SENSE_LOW_LEVEL && older_core_i // R06 R20
                                 |=> !pin_req[0] || ($past(irq_pin_i[0], 2) && !$past(irq_pin_i[0])))
    else $error("Edge request not cleared after acceptance.");

  // Main entry scenarios worth seeing.
  nmi_entry_c: cover property (nmi_req ##1 push_pc_o ##[1:20] service_start_o);
  combined_c: cover property (mode == MODE_COMBINED && global_mask_i && best_valid ##1 push_pc_o);
  trap_entry_c: cover property (trap_ok ##1 push_pc_o ##[1:20] service_start_o);
  sleep_wake_c: cover property (cpu_sleeping_i ##1 wake_o);
  preempt_c: cover property (mode == MODE_USER && global_mask_i && !user_mask_bit_i && best_valid);

endmodule

// File: dv/cpu_seq_model.sv
// Behavioural CPU sequencer model that answers the exception entry strobes.
`timescale 1ns/100ps
module cpu_seq_model (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic [1:0] delay_i,
  input  wire logic       push_pc_i,
  input  wire logic       push_flags_i,
  input  wire logic       fetch_vector_i,
  output logic            stack_ack_o,
  output logic            fetch_ack_o
);
  logic [1:0] wait_q;
  logic       busy_w;
  logic       ack_w;

  // A strobe is answered only while it stands, after it has stood delay_i cycles.
  assign busy_w      = push_pc_i | push_flags_i | fetch_vector_i;
  assign ack_w       = busy_w && (wait_q >= delay_i);
  assign stack_ack_o = ack_w && (push_pc_i || push_flags_i);
  assign fetch_ack_o = ack_w && fetch_vector_i;

  // The wait counter restarts after every answer so each push waits afresh.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_q <= 2'h0;
    end else if (ack_w || !busy_w) begin
      wait_q <= 2'h0;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule

// File: dv/test_exception_interrupt_priority_ctrl.sv
// Self-checking testbench of the exception and interrupt priority controller.
`timescale 1ns/100ps
module test_exception_interrupt_priority_ctrl;
  import exc_ctrl_pkg::*;
  logic        clock_i, reset_n_i, nmi_pin_i, nmi_rising_i, older_core_i, global_mask_i, user_mask_bit_i;
  logic        trap_req_i, cpu_executing_i, cpu_sleeping_i, stack_ack_i, fetch_ack_i;
  logic [7:0]  irq_pin_i, periph_req_i, vector_o;
  logic [15:0] irq_sense_i;
  logic [47:0] prio_i;
  logic [1:0]  mode_i, trap_operand_i, delay_q;
  logic [2:0]  mask_level_field_i, mask_level_field_o;
  logic        push_pc_o, push_flags_o, mask_write_o, global_mask_o, user_mask_bit_o;
  logic        fetch_vector_o, service_start_o, wake_o, latency_error_o;
  wire logic [4:0] phase_w = {service_start_o, fetch_vector_o, mask_write_o, push_flags_o, push_pc_o};
  int          error_cnt, cmp_count;

  exception_interrupt_priority_ctrl dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .nmi_pin_i(nmi_pin_i),
    .nmi_rising_i(nmi_rising_i), .irq_pin_i(irq_pin_i), .irq_sense_i(irq_sense_i), .older_core_i(older_core_i),
    .periph_req_i(periph_req_i), .source_priority_register_i(prio_i), .mode_i(mode_i),
    .global_mask_i(global_mask_i), .user_mask_bit_i(user_mask_bit_i), .mask_level_field_i(mask_level_field_i),
    .trap_req_i(trap_req_i), .trap_operand_i(trap_operand_i), .cpu_executing_i(cpu_executing_i),
    .cpu_sleeping_i(cpu_sleeping_i), .stack_ack_i(stack_ack_i), .fetch_ack_i(fetch_ack_i),
    .push_pc_o(push_pc_o), .push_flags_o(push_flags_o), .mask_write_o(mask_write_o),
    .global_mask_o(global_mask_o), .user_mask_bit_o(user_mask_bit_o), .mask_level_field_o(mask_level_field_o),
    .fetch_vector_o(fetch_vector_o), .vector_o(vector_o), .service_start_o(service_start_o), .wake_o(wake_o),
    .latency_error_o(latency_error_o));

  cpu_seq_model cpu_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .delay_i(delay_q), .push_pc_i(push_pc_o),
    .push_flags_i(push_flags_o), .fetch_vector_i(fetch_vector_o), .stack_ack_o(stack_ack_i),
    .fetch_ack_o(fetch_ack_i));

  // ----------------------------------------------------------------
  // Shared checks and the entry walk
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // Waits up to 40 cycles for entry phase k; a missing phase ends the test.
  task automatic wait_phase(input int k);
    int n;
    n = 0;
    @(negedge clock_i);
    while (phase_w[k] !== 1'b1 && n < 40) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 40) begin
      error_cnt++;
      $display("wrong value at %0t: entry phase %0d missing", $time, k);
      give_verdict();
    end
  endtask

  // Follows one whole entry and loads the new masks as the CPU would.
  task automatic entry(input logic [7:0] vec, input logic gm, input logic [2:0] lvl);
    wait_phase(0);
    check(vector_o === vec, "vector number");
    wait_phase(1);
    wait_phase(2);
    check(global_mask_o === gm && mask_level_field_o === lvl, "mask update");
    @(posedge clock_i);
    global_mask_i      <= global_mask_o;
    user_mask_bit_i    <= user_mask_bit_o;
    mask_level_field_i <= mask_level_field_o;
    wait_phase(3);
    wait_phase(4);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic global_mode();
    int n;
    @(posedge clock_i);
    global_mask_i   <= 1'b0;
    periph_req_i[2] <= 1'b1;
    entry(VEC_SRC_BASE + 8'h0A, 1'b1, 3'h7);
    for (n = 0; n < 10; n++) begin
      @(negedge clock_i);
      check(push_pc_o === 1'b0, "masked request taken");
    end
    @(posedge clock_i);
    periph_req_i[2] <= 1'b0;
  endtask

  task automatic traps();
    int n;
    for (n = 0; n < 4; n++) begin
      @(posedge clock_i);
      delay_q        <= 2'h2;
      trap_req_i     <= 1'b1;
      trap_operand_i <= n[1:0];
      @(posedge clock_i);
      trap_req_i <= 1'b0;
      entry(VEC_TRAP_BASE + 8'(n), 1'b1, 3'h7);
    end
  endtask

  task automatic nmi_edges();
    @(posedge clock_i);
    delay_q   <= 2'h0;
    nmi_pin_i <= 1'b0;
    @(posedge clock_i);
    nmi_pin_i <= 1'b1;
    entry(VEC_NMI, 1'b1, 3'h7);
    @(posedge clock_i);
    nmi_rising_i <= 1'b0;
    nmi_pin_i    <= 1'b0;
    entry(VEC_NMI, 1'b1, 3'h7);
  endtask

  task automatic priority_levels();
    @(posedge clock_i);
    mode_i             <= MODE_LEVEL;
    mask_level_field_i <= 3'h2;
    prio_i[24 +: 3]    <= 3'h3;
    prio_i[27 +: 3]    <= 3'h5;
    periph_req_i[1:0]  <= 2'h3;
    entry(VEC_SRC_BASE + 8'h09, 1'b1, 3'h5);
    @(posedge clock_i);
    periph_req_i[1]    <= 1'b0;
    mask_level_field_i <= 3'h2;
    entry(VEC_SRC_BASE + 8'h08, 1'b1, 3'h3);
    @(posedge clock_i);
    periph_req_i[0]    <= 1'b0;
    mode_i             <= MODE_GLOBAL;
    mask_level_field_i <= 3'h7;
  endtask

  task automatic user_modes();
    int m, n;
    for (m = 1; m < 4; m += 2) begin
      @(posedge clock_i);
      {mode_i, global_mask_i, user_mask_bit_i, mask_level_field_i} <= {m[1:0], 5'h12};
      periph_req_i[1] <= 1'b1;
      entry(VEC_SRC_BASE + 8'h09, 1'b1, m[1] ? 3'h5 : 3'h2);
      check(user_mask_bit_o === 1'b1, "user mask not set");
      @(posedge clock_i);
      mask_level_field_i <= 3'h2;
      for (n = 0; n < 6; n++) begin
        @(negedge clock_i);
        check(push_pc_o === 1'b0, "user mask ignored");
      end
      @(posedge clock_i);
      {mode_i, periph_req_i[1], user_mask_bit_i, mask_level_field_i} <= 7'h07;
    end
  endtask

  task automatic sleep_wake();
    int n;
    @(posedge clock_i);
    global_mask_i    <= 1'b0;
    cpu_sleeping_i   <= 1'b1;
    irq_sense_i[7:6] <= SENSE_FALL;
    @(posedge clock_i);
    irq_pin_i[3] <= 1'b0;
    @(posedge clock_i);
    irq_pin_i[3] <= 1'b1;
    fork
      entry(VEC_SRC_BASE + 8'h03, 1'b1, 3'h7);
      begin
        for (n = 0; n < 8 && wake_o !== 1'b1; n++) @(negedge clock_i);
        check(wake_o === 1'b1, "sleep not left");
      end
    join
    @(posedge clock_i);
    cpu_sleeping_i <= 1'b0;
  endtask

  task automatic older_core();
    @(posedge clock_i);
    older_core_i     <= 1'b1;
    irq_sense_i[1:0] <= SENSE_RISE;
    global_mask_i    <= 1'b0;
    @(posedge clock_i);
    irq_pin_i[0] <= 1'b0;
    entry(VEC_SRC_BASE + 8'h00, 1'b1, 3'h7);
    check(latency_error_o === 1'b0, "response too slow");
  endtask

  // ----------------------------------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    {reset_n_i, older_core_i, user_mask_bit_i, trap_req_i, cpu_sleeping_i} = 5'h00;
    {nmi_pin_i, nmi_rising_i, global_mask_i, cpu_executing_i} = 4'hF;
    {irq_pin_i, periph_req_i, irq_sense_i} = 32'hFF000000;
    {prio_i, mode_i, trap_operand_i, delay_q, mask_level_field_i} = 57'h7;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(negedge clock_i);
    check(global_mask_o === GMASK_RESET && user_mask_bit_o === UMASK_RESET, "reset masks");
    check(mask_level_field_o === LEVEL_RESET && phase_w === 5'h00 && wake_o === 1'b0, "reset outputs");
    global_mode();
    traps();
    nmi_edges();
    priority_levels();
    user_modes();
    sleep_wake();
    older_core();
    give_verdict();
  end
endmodule
